// [design/mpw_top.v]
// Ten-bit three-phase motor PWM generator with output mask logic and an AHB-Lite slave.
// Assumes one 10 MHz clock that is also the PWM base clock, and a single bus master.
// Contract
// - Counter period and duty each come from a separate 10-bit software register.
// - Alignment field: upper bit zero edge-aligned, 10 center mode 1, 11 center mode 2.
// - Counter clock select divides base clock by 1, 2, 4 or 8.
// - Run bit one counts; zero stops counting and turns the PWM output off.
// - Center duty interrupt: never, counting up, counting down, or both.
// - Load bit zero blocks new values; one loads at underflow, then self-clears. With load zero, a sync request still applies duties 0..2.
// - Mirror bit copies every channel-0 duty write into channels 1 and 2.
// - Sync request with sync enable applies duties 0..2 together, then clears.
// - Fourth duty pair is storage only and drives no output.
// - Counter pair reads live count: bits 7..0 low, bits 9..8 high.
// - Unimplemented bits of sync, high-byte and counter registers read zero.
// - Mask has normal, brake and protect modes; normal has hardware and software.
// - Arm select zero modulates bottom arms, one modulates top arms.
// - Modulation enable one lets outputs carry PWM; zero removes modulation.
// - Hardware output style zero complementary, one non-complementary.
// - Mask mode select zero hardware mask, one software mask.
// - Brake overrides all: tops off, bottoms on.
// - Protect: select zero all off, one tops off and bottoms on.
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "mpw_regs.vh"

module mpw_top #(
  parameter W = 10
) (
  input wire clock,
  input wire arst_n,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output reg phase_a_top_gate,
  output reg phase_a_bottom_gate,
  output reg phase_b_top_gate,
  output reg phase_b_bottom_gate,
  output reg phase_c_top_gate,
  output reg phase_c_bottom_gate,
  output reg modulated_signal,
  output reg duty_irq
);

  reg [7:0] pwm_control;
  reg [2:0] duty_sync_control;
  reg [7:0] mask_control_flags;
  reg [1:0] mode_control;
  reg [5:0] commutation;
  reg [5:0] sw_mask_enable;
  reg [5:0] sw_mask_data;
  reg [W-9:0] high_buffer;
  reg [W-1:0] duty_reg [0:3];
  reg [W-1:0] duty_act [0:2];
  reg [W-1:0] period_reg;
  reg [W-1:0] period_act;
  reg [W-1:0] count;
  reg count_down;
  reg [2:0] prescale;
  reg wr_pend;
  reg [7:0] wr_addr;
  reg [31:0] next_rdata;
  reg [2:0] div_mask;

  wire [1:0] alignment_select = pwm_control[`MPW_CTRL_ALIGN_HI:`MPW_CTRL_ALIGN_LO];
  wire [1:0] counter_clock_divide = pwm_control[`MPW_CTRL_DIV_HI:`MPW_CTRL_DIV_LO];
  wire counter_run = pwm_control[`MPW_CTRL_RUN];
  wire [1:0] center_duty_irq_select = pwm_control[`MPW_CTRL_IRQ_HI:`MPW_CTRL_IRQ_LO];
  wire shadow_load_control = pwm_control[`MPW_CTRL_LOAD];
  wire sync_update_request = duty_sync_control[`MPW_SYNC_REQ];
  wire sync_update_enable = duty_sync_control[`MPW_SYNC_EN];
  wire duty_mirror_enable = duty_sync_control[`MPW_SYNC_MIRROR];
  wire mask_mode_select = mask_control_flags[`MPW_MASK_SWMODE];
  wire hw_mask_output_style = mask_control_flags[`MPW_MASK_NONCOMP];
  wire modulation_output_enable = mask_control_flags[`MPW_MASK_MODEN];
  wire protect_output_select = mask_control_flags[`MPW_MASK_PROTSEL];
  wire arm_port_select = mask_control_flags[`MPW_MASK_TOPSEL];
  wire brake_enable = mode_control[`MPW_MODE_BRAKE];
  wire protect_enable = mode_control[`MPW_MODE_PROTECT];

  wire [7:0] wr_data_byte = hwdata[7:0];
  wire [W-1:0] low_value = {high_buffer, wr_data_byte};
  wire center_mode = alignment_select[1];
  wire [W:0] count_inc = {1'b0, count} + {{W{1'b0}}, 1'b1};

  // Data phase of a write is the cycle after its address phase; the slave never waits.
  wire wr_now = wr_pend;
  wire wr_ctrl = wr_now && (wr_addr == `MPW_OFS_CTRL);
  wire wr_sync = wr_now && (wr_addr == `MPW_OFS_SYNC);

  // Prescaler tick: the mask selects how many base cycles form one count step.
  always @*
  begin
    case (counter_clock_divide)
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  wire tick = counter_run && ((prescale & div_mask) == div_mask);
  wire edge_wrap = count_inc >= {1'b0, period_act};
  wire at_top = count >= period_act;
  wire underflow = tick && (center_mode ? (count_down && count == {W{1'b0}}) || at_top &&
    period_act == {W{1'b0}} : edge_wrap);
  // Center mode 2 also refreshes at the turning point at the top of the ramp.
  wire top_turn = tick && center_mode && alignment_select[0] && !count_down && at_top;
  wire refresh = underflow || top_turn;
  wire do_load = refresh && shadow_load_control;
  wire do_sync = refresh && sync_update_enable && sync_update_request;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prescale <= 3'h0;
    end
    else
    begin
      prescale <= counter_run ? prescale + 3'h1 : 3'h0;
    end
  end

  // The counter holds its value while stopped so software can still read it.
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= {W{1'b0}};
      count_down <= 1'b0;
    end
    else if (tick)
    begin
      if (!center_mode)
      begin
        count_down <= 1'b0;
        count <= edge_wrap ? {W{1'b0}} : count_inc[W-1:0];
      end
      else if (period_act == {W{1'b0}})
      begin
        count <= {W{1'b0}};
        count_down <= 1'b0;
      end
      else if (!count_down)
      begin
        if (at_top)
        begin
          count_down <= 1'b1;
          count <= period_act - {{(W-1){1'b0}}, 1'b1};
        end
        else
        begin
          count <= count_inc[W-1:0];
        end
      end
      else if (count == {W{1'b0}})
      begin
        count_down <= 1'b0;
        count <= {{(W-1){1'b0}}, 1'b1};
      end
      else
      begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Bus address phase: capture the transfer and present read data at its data phase.
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1])
      begin
        wr_pend <= hwrite;
        wr_addr <= haddr;
        hrdata <= hwrite ? 32'h00000000 : next_rdata;
      end
      else
      begin
        wr_pend <= 1'b0;
      end
    end
  end

  always @*
  begin
    next_rdata = 32'h00000000;
    case (haddr)
      `MPW_OFS_CTRL: next_rdata[7:0] = pwm_control;
      `MPW_OFS_SYNC: next_rdata[2:0] = duty_sync_control;
      `MPW_OFS_DUTY0_LO: next_rdata[7:0] = duty_reg[0][7:0];
      `MPW_OFS_DUTY0_HI: next_rdata[W-9:0] = duty_reg[0][W-1:8];
      `MPW_OFS_DUTY1_LO: next_rdata[7:0] = duty_reg[1][7:0];
      `MPW_OFS_DUTY1_HI: next_rdata[W-9:0] = duty_reg[1][W-1:8];
      `MPW_OFS_DUTY2_LO: next_rdata[7:0] = duty_reg[2][7:0];
      `MPW_OFS_DUTY2_HI: next_rdata[W-9:0] = duty_reg[2][W-1:8];
      `MPW_OFS_DUTY3_LO: next_rdata[7:0] = duty_reg[3][7:0];
      `MPW_OFS_DUTY3_HI: next_rdata[W-9:0] = duty_reg[3][W-1:8];
      `MPW_OFS_PER_LO: next_rdata[7:0] = period_reg[7:0];
      `MPW_OFS_PER_HI: next_rdata[W-9:0] = period_reg[W-1:8];
      `MPW_OFS_CNT_LO: next_rdata[7:0] = count[7:0];
      `MPW_OFS_CNT_HI: next_rdata[W-9:0] = count[W-1:8];
      `MPW_OFS_MASK: next_rdata[7:0] = mask_control_flags;
      `MPW_OFS_MODE: next_rdata[1:0] = mode_control;
      `MPW_OFS_COMM: next_rdata[5:0] = commutation;
      `MPW_OFS_SWEN: next_rdata[5:0] = sw_mask_enable;
      `MPW_OFS_SWDAT: next_rdata[5:0] = sw_mask_data;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Control registers. A software set of a self-clearing bit wins over the hardware clear.
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_control <= `MPW_RST_CTRL;
      duty_sync_control <= `MPW_RST_SYNC;
      mask_control_flags <= `MPW_RST_MASK;
      mode_control <= `MPW_RST_MODE;
      commutation <= 6'h00;
      sw_mask_enable <= 6'h00;
      sw_mask_data <= 6'h00;
    end
    else
    begin
      if (wr_ctrl)
      begin
        pwm_control <= wr_data_byte;
      end
      else if (do_load)
      begin
        pwm_control[`MPW_CTRL_LOAD] <= 1'b0;
      end
      if (wr_sync)
      begin
        duty_sync_control <= wr_data_byte[2:0];
      end
      else if (do_sync)
      begin
        duty_sync_control[`MPW_SYNC_REQ] <= 1'b0;
      end
      if (wr_now)
      begin
        case (wr_addr)
          `MPW_OFS_MASK: mask_control_flags <= wr_data_byte & `MPW_MASK_IMPL;
          `MPW_OFS_MODE: mode_control <= wr_data_byte[1:0];
          `MPW_OFS_COMM: commutation <= wr_data_byte[5:0];
          `MPW_OFS_SWEN: sw_mask_enable <= wr_data_byte[5:0];
          `MPW_OFS_SWDAT: sw_mask_data <= wr_data_byte[5:0];
          default: mode_control <= mode_control;
        endcase
      end
    end
  end

  // Software-side value registers; only one shared high-byte buffer is kept,
  // which is enough because every pair is written high byte then low byte.
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      high_buffer <= {(W-8){1'b0}};
      period_reg <= {W{1'b0}};
      duty_reg[0] <= {W{1'b0}};
      duty_reg[1] <= {W{1'b0}};
      duty_reg[2] <= {W{1'b0}};
      duty_reg[3] <= {W{1'b0}};
    end
    else if (wr_now)
    begin
      case (wr_addr)
        `MPW_OFS_DUTY0_HI, `MPW_OFS_DUTY1_HI, `MPW_OFS_DUTY2_HI, `MPW_OFS_DUTY3_HI,
        `MPW_OFS_PER_HI: high_buffer <= wr_data_byte[W-9:0];
        `MPW_OFS_DUTY0_LO:
        begin
          duty_reg[0] <= low_value;
          if (duty_mirror_enable)
          begin
            duty_reg[1] <= low_value;
            duty_reg[2] <= low_value;
          end
        end
        `MPW_OFS_DUTY1_LO: duty_reg[1] <= low_value;
        `MPW_OFS_DUTY2_LO: duty_reg[2] <= low_value;
        `MPW_OFS_DUTY3_LO: duty_reg[3] <= low_value;
        `MPW_OFS_PER_LO: period_reg <= low_value;
        default: high_buffer <= high_buffer;
      endcase
    end
  end

  // Compare values used by the counter; fourth duty never reaches this stage.
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      period_act <= {W{1'b0}};
      duty_act[0] <= {W{1'b0}};
      duty_act[1] <= {W{1'b0}};
      duty_act[2] <= {W{1'b0}};
    end
    else
    begin
      if (do_load)
      begin
        period_act <= period_reg;
      end
      if (do_load || do_sync)
      begin
        duty_act[0] <= duty_reg[0];
        duty_act[1] <= duty_reg[1];
        duty_act[2] <= duty_reg[2];
      end
    end
  end

  genvar i;
  wire [2:0] chan_pwm;
  wire [2:0] channel_match;
  wire [5:0] next_gate;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_phase
      wire pwm_on = counter_run && (count < duty_act[i]);
      wire pwm_eff = modulation_output_enable ? pwm_on : 1'b1;
      wire pwm_cmp = hw_mask_output_style ? 1'b0 : !pwm_eff;
      wire top_sel = commutation[2*i];
      wire bot_sel = commutation[2*i+1];
      wire hw_top = (top_sel && !bot_sel) ? (arm_port_select ? pwm_eff : 1'b1) :
        (!top_sel && bot_sel) ? (arm_port_select ? 1'b0 : pwm_cmp) : 1'b0;
      wire hw_bot = (top_sel && !bot_sel) ? (arm_port_select ? pwm_cmp : 1'b0) :
        (!top_sel && bot_sel) ? (arm_port_select ? 1'b1 : pwm_eff) : 1'b0;
      wire both_forced = sw_mask_enable[2*i] && sw_mask_enable[2*i+1] &&
        sw_mask_data[2*i] && sw_mask_data[2*i+1];
      wire sw_top = both_forced ? 1'b0 : sw_mask_enable[2*i] ? sw_mask_data[2*i] : pwm_eff;
      wire sw_bot = both_forced ? 1'b0 :
        sw_mask_enable[2*i+1] ? sw_mask_data[2*i+1] : !pwm_eff;
      wire norm_top = mask_mode_select ? sw_top : hw_top;
      wire norm_bot = mask_mode_select ? sw_bot : hw_bot;
      assign chan_pwm[i] = pwm_on;
      assign channel_match[i] = count == duty_act[i];
      // Brake first, then protect, then the normal sub-modes.
      assign next_gate[2*i] = brake_enable ? 1'b0 : protect_enable ? 1'b0 : norm_top;
      assign next_gate[2*i+1] = brake_enable ? 1'b1 :
        protect_enable ? protect_output_select : norm_bot;
    end
  endgenerate

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_a_top_gate <= 1'b0;
      phase_a_bottom_gate <= 1'b0;
      phase_b_top_gate <= 1'b0;
      phase_b_bottom_gate <= 1'b0;
      phase_c_top_gate <= 1'b0;
      phase_c_bottom_gate <= 1'b0;
      modulated_signal <= 1'b0;
      duty_irq <= 1'b0;
    end
    else
    begin
      phase_a_top_gate <= next_gate[0];
      phase_a_bottom_gate <= next_gate[1];
      phase_b_top_gate <= next_gate[2];
      phase_b_bottom_gate <= next_gate[3];
      phase_c_top_gate <= next_gate[4];
      phase_c_bottom_gate <= next_gate[5];
      modulated_signal <= chan_pwm[0];
      duty_irq <= tick && center_mode && (|channel_match) &&
        (count_down ? center_duty_irq_select[1] : center_duty_irq_select[0]);
    end
  end

endmodule // mpw_top

// [design/mpw_regs.vh]
// Register map, field positions and reset values of the motor PWM block.
// Assumes byte addressing on a 32-bit AHB-Lite bus with one register per word.
`ifndef MPW_REGS_VH
`define MPW_REGS_VH

`define MPW_OFS_CTRL 8'h00
`define MPW_OFS_SYNC 8'h04
`define MPW_OFS_DUTY0_LO 8'h08
`define MPW_OFS_DUTY0_HI 8'h0C
`define MPW_OFS_DUTY1_LO 8'h10
`define MPW_OFS_DUTY1_HI 8'h14
`define MPW_OFS_DUTY2_LO 8'h18
`define MPW_OFS_DUTY2_HI 8'h1C
`define MPW_OFS_DUTY3_LO 8'h20
`define MPW_OFS_DUTY3_HI 8'h24
`define MPW_OFS_PER_LO 8'h28
`define MPW_OFS_PER_HI 8'h2C
`define MPW_OFS_CNT_LO 8'h30
`define MPW_OFS_CNT_HI 8'h34
`define MPW_OFS_MASK 8'h38
`define MPW_OFS_MODE 8'h3C
`define MPW_OFS_COMM 8'h40
`define MPW_OFS_SWEN 8'h44
`define MPW_OFS_SWDAT 8'h48

// pwm_control fields.
`define MPW_CTRL_ALIGN_HI 7
`define MPW_CTRL_ALIGN_LO 6
`define MPW_CTRL_DIV_HI 5
`define MPW_CTRL_DIV_LO 4
`define MPW_CTRL_RUN 3
`define MPW_CTRL_IRQ_HI 2
`define MPW_CTRL_IRQ_LO 1
`define MPW_CTRL_LOAD 0
// duty_sync_control fields.
`define MPW_SYNC_REQ 2
`define MPW_SYNC_EN 1
`define MPW_SYNC_MIRROR 0
// mask_control_flags fields.
`define MPW_MASK_SWMODE 7
`define MPW_MASK_NONCOMP 3
`define MPW_MASK_MODEN 2
`define MPW_MASK_PROTSEL 1
`define MPW_MASK_TOPSEL 0
// Mode register fields.
`define MPW_MODE_BRAKE 0
`define MPW_MODE_PROTECT 1

`define MPW_RST_CTRL 8'h00
`define MPW_RST_SYNC 3'h0
`define MPW_RST_MASK 8'h04
`define MPW_MASK_IMPL 8'h8F
`define MPW_RST_MODE 2'h0

`endif

// [testbench/mpw_gate_drv.sv]
// Model of the three external gate-driver transistor pairs.
// Assumes active-high gate drives; both gates of a pair on is a shoot-through.
module mpw_gate_drv (
  input wire clock,
  input wire arst_n,
  input wire [5:0] gates,
  output logic shoot_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clock or negedge arst_n)
    if (!arst_n)
      shoot_seen <= 1'b0;
    else if ((gates[0] & gates[1]) | (gates[2] & gates[3]) | (gates[4] & gates[5]))
      shoot_seen <= 1'b1;
endmodule // mpw_gate_drv

// [testbench/mpw_asserts.sv]
// Port-level assertions for the motor PWM block, bound into mpw_top.
// Assumes registers are written only over the block's AHB-Lite port.
`include "mpw_regs.vh"
module mpw_asserts (
  input wire clock,
  input wire arst_n,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire phase_a_top_gate,
  input wire phase_a_bottom_gate,
  input wire phase_b_top_gate,
  input wire phase_b_bottom_gate,
  input wire phase_c_top_gate,
  input wire phase_c_bottom_gate,
  input wire modulated_signal,
  input wire duty_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Shadows of written registers; checks wait a cycle so the gate stage can follow.
  reg wp;
  reg [7:0] wa, ctl, msk;
  reg [1:0] mde;
  wire [2:0] tops = {phase_a_top_gate, phase_b_top_gate, phase_c_top_gate};
  wire [2:0] bots = {phase_a_bottom_gate, phase_b_bottom_gate, phase_c_bottom_gate};
  always @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      wp <= 1'b0;
      wa <= 8'h00;
      ctl <= 8'h00;
      msk <= 8'h04;
      mde <= 2'h0;
    end
    else
    begin
      wp <= hsel && htrans[1] && hready && hwrite;
      wa <= haddr;
      if (wp && wa == `MPW_OFS_CTRL)
        ctl <= hwdata[7:0];
      if (wp && wa == `MPW_OFS_MASK)
        msk <= hwdata[7:0];
      if (wp && wa == `MPW_OFS_MODE)
        mde <= hwdata[1:0];
    end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  chk_read_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  chk_irq_one_cycle: assert property (duty_irq |=> !duty_irq)
    else $error("duty interrupt longer than a cycle");
  chk_irq_edge_quiet: assert property (!ctl[7] && !$past(ctl[7]) |-> !duty_irq)
    else $error("duty interrupt in edge mode");
  chk_irq_select_off: assert property (ctl[2:1] == 2'h0
    && $past(ctl[2:1]) == 2'h0 |-> !duty_irq)
    else $error("duty interrupt while disabled");
  chk_stop_output_low: assert property (!ctl[3] && !$past(ctl[3]) |-> !modulated_signal)
    else $error("output active while stopped");
  chk_brake_gates: assert property (mde[0] && $past(mde[0])
    |-> tops == 3'h0 && bots == 3'h7)
    else $error("brake gates wrong");
  chk_protect_gates: assert property (mde == 2'h2 && $past(mde) == 2'h2 && $stable(msk)
    |-> tops == 3'h0 && bots == {3{msk[1]}})
    else $error("protect gates wrong");
  chk_pair_exclusive: assert property ((tops & bots) == 3'h0)
    else $error("both gates of a pair on");
  cov_irq: cover property (duty_irq);
  cov_brake: cover property (mde[0] && bots == 3'h7);
  cov_pwm_rise: cover property ($rose(modulated_signal));
endmodule // mpw_asserts
bind mpw_top mpw_asserts chk (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .phase_a_top_gate(phase_a_top_gate), .phase_a_bottom_gate(phase_a_bottom_gate),
  .phase_b_top_gate(phase_b_top_gate), .phase_b_bottom_gate(phase_b_bottom_gate),
  .phase_c_top_gate(phase_c_top_gate), .phase_c_bottom_gate(phase_c_bottom_gate),
  .modulated_signal(modulated_signal), .duty_irq(duty_irq));

// [testbench/testbench.sv]
// Self-checking bench for the motor PWM block over its AHB-Lite port.
// Assumes zero-wait answers and the gate-driver model at the outputs.
`include "mpw_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire hready, hresp, pwm, irq, shoot;
  wire [31:0] hrdata;
  wire [5:0] g;
  int n_errors = 0;
  int compares = 0;
  int cnt[8];
  always #50 clock = ~clock;
  mpw_top #(.W(10)) dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .phase_a_top_gate(g[0]),
    .phase_a_bottom_gate(g[1]), .phase_b_top_gate(g[2]), .phase_b_bottom_gate(g[3]),
    .phase_c_top_gate(g[4]), .phase_c_bottom_gate(g[5]), .modulated_signal(pwm),
    .duty_irq(irq));
  mpw_gate_drv drv (.clock(clock), .arst_n(arst_n), .gates(g), .shoot_seen(shoot));
  task give_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    check(rd, {24'h0, e});
  endtask
  task wr10(input logic [7:0] a, input logic [9:0] v);
    wr(a + 8'h04, {6'h0, v[9:8]});
    wr(a, v[7:0]);
  endtask
  // Forty cycles span whole periods, so the counts do not depend on phase.
  task win;
    int k;
    repeat (12) @(negedge clock);
    cnt = '{default: 0};
    repeat (40)
    begin
      @(negedge clock);
      for (k = 0; k < 6; k++)
        cnt[k] += int'(g[k] === 1'b1);
      cnt[6] += int'(pwm === 1'b1);
      cnt[7] += int'(irq === 1'b1);
    end
  endtask
  task eg(input int a0, a1, b0, b1, c0, c1);
    int e[6];
    e = '{a0, a1, b0, b1, c0, c1};
    win;
    foreach (e[k])
      check(cnt[k], e[k]);
  endtask
  task lvl(input logic v, inout int t);
    int n;
    for (n = 0; n < 400 && pwm !== v; n++)
    begin
      @(negedge clock);
      t++;
    end
  endtask
  task gap(output int t);
    @(negedge clock);
    lvl(1'b0, t);
    lvl(1'b1, t);
    t = 0;
    lvl(1'b0, t);
    lvl(1'b1, t);
  endtask
  task t_regs;
    rdchk(`MPW_OFS_CTRL, 8'h00);
    rdchk(`MPW_OFS_MASK, 8'h04);
    rdchk(`MPW_OFS_PER_HI, 8'h00);
    rdchk(8'hFC, 8'h00);
    wr(`MPW_OFS_CNT_LO, 8'hFF);
    rdchk(`MPW_OFS_CNT_LO, 8'h00);
    $display("t_regs done");
  endtask
  task t_pairs;
    wr10(`MPW_OFS_DUTY0_LO, 10'h123);
    rdchk(`MPW_OFS_DUTY1_LO, 8'h00);
    wr(`MPW_OFS_DUTY0_HI, 8'hFF);
    rdchk(`MPW_OFS_DUTY0_HI, 8'h01);
    wr(`MPW_OFS_SYNC, 8'hF9);
    rdchk(`MPW_OFS_SYNC, 8'h01);
    wr(`MPW_OFS_DUTY0_LO, 8'h45);
    rdchk(`MPW_OFS_DUTY0_HI, 8'h03);
    rdchk(`MPW_OFS_DUTY2_LO, 8'h45);
    wr10(`MPW_OFS_DUTY0_LO, 10'h005);
    rdchk(`MPW_OFS_DUTY1_HI, 8'h00);
    wr10(`MPW_OFS_DUTY3_LO, 10'h2A5);
    rdchk(`MPW_OFS_DUTY3_HI, 8'h02);
    $display("t_pairs done");
  endtask
  task t_count;
    int k, t;
    logic [31:0] hold;
    wr10(`MPW_OFS_PER_LO, 10'h00A);
    wr(`MPW_OFS_CTRL, 8'h08);
    win;
    check(cnt[6], 0);
    rdchk(`MPW_OFS_CNT_LO, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      wr(`MPW_OFS_CTRL, {2'b00, k[1:0], 4'h9});
      gap(t);
      check(t, 10 << k);
    end
    rdchk(`MPW_OFS_CTRL, 8'h38);
    wr(`MPW_OFS_CTRL, 8'h00);
    xfer(`MPW_OFS_CNT_LO, 1'b0, 8'h00);
    hold = rd;
    check(32'(hold < 32'd10), 32'd1);
    win;
    check(cnt[6], 0);
    rdchk(`MPW_OFS_CNT_LO, hold[7:0]);
    rdchk(`MPW_OFS_CNT_HI, 8'h00);
    $display("t_count done");
  endtask
  task t_center;
    int k, m, t;
    for (m = 2; m < 4; m++)
    begin
      for (k = 0; k < 4; k++)
      begin
        wr(`MPW_OFS_CTRL, {m[1:0], 3'b001, k[1:0], 1'b1});
        win;
        check(cnt[7], k == 0 ? 0 : (k == 3 ? 4 : 2));
      end
      gap(t);
      check(t, 20);
    end
    wr(`MPW_OFS_CTRL, 8'h0F);
    win;
    check(cnt[7], 0);
    $display("t_center done");
  endtask
  task t_sync;
    wr(`MPW_OFS_CTRL, 8'h08);
    wr(`MPW_OFS_SYNC, 8'h03);
    wr10(`MPW_OFS_DUTY0_LO, 10'h002);
    win;
    check(cnt[6], 20);
    wr(`MPW_OFS_SYNC, 8'h07);
    win;
    check(cnt[6], 8);
    rdchk(`MPW_OFS_SYNC, 8'h03);
    $display("t_sync done");
  endtask
  task t_mask;
    int s, c;
    wr(`MPW_OFS_COMM, 8'h09);
    for (s = 0; s < 2; s++)
      for (c = 0; c < 2; c++)
      begin
        wr(`MPW_OFS_MASK, {4'h0, c[0], 2'b10, s[0]});
        eg(s ? 8 : 40, s ? (c ? 0 : 32) : 0, s ? 0 : (c ? 0 : 32), s ? 40 : 8, 0, 0);
      end
    wr(`MPW_OFS_MASK, 8'h00);
    eg(40, 0, 0, 40, 0, 0);
    wr(`MPW_OFS_MASK, 8'h84);
    eg(8, 32, 8, 32, 8, 32);
    wr(`MPW_OFS_SWEN, 8'h3F);
    wr(`MPW_OFS_SWDAT, 8'h07);
    eg(0, 0, 40, 0, 0, 0);
    wr(`MPW_OFS_MODE, 8'h03);
    eg(0, 40, 0, 40, 0, 40);
    wr(`MPW_OFS_MODE, 8'h02);
    eg(0, 0, 0, 0, 0, 0);
    wr(`MPW_OFS_MASK, 8'h86);
    eg(0, 40, 0, 40, 0, 40);
    $display("t_mask done");
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_regs;
    t_pairs;
    t_count;
    t_center;
    t_sync;
    t_mask;
    check({31'h0, shoot}, 32'h0);
    give_verdict;
  end
  // The tests need a few thousand cycles; twenty thousand means a hang.
  initial
  begin
    #2000000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict;
  end
endmodule // testbench
